/* rtl/lock_rotor_protect_drive.sv */
// Locked-rotor protection, current limit response, speed pulse and gate drive
`timescale 1ns/1ns
`default_nettype none
`include "lrp_defs.svh"

module lock_rotor_protect_drive #(
  parameter int unsigned RUN_LOCK_CYC   = `LRP_RUN_LOCK_CYC,
  parameter int unsigned START_LOCK_CYC = `LRP_START_LOCK_CYC,
  parameter int unsigned OFF_EARLY_CYC  = `LRP_OFF_EARLY_CYC,
  parameter int unsigned OFF_LATE_CYC   = `LRP_OFF_LATE_CYC,
  parameter int unsigned RESTART_ON_CYC = `LRP_RESTART_ON_CYC
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  input  wire logic          run_cmd,
  input  wire logic          hall_in_pos,
  input  wire logic          hall_in_neg,
  input  wire logic          current_sense_in,
  output lrp_pkg::gate_drive_t gate_drive,
  output logic               speed_pulse_out_o,
  output logic               speed_pulse_out_oe,
  output logic               overcurrent_limiter,
  output logic               rotor_locked,
  output logic [2:0]         off_period_count
);
  import lrp_pkg::*;

  localparam logic [2:0] EARLY_PERIODS = 3'(`LRP_EARLY_OFF_PERIODS);

  if (RUN_LOCK_CYC < 1 || START_LOCK_CYC < 1 || OFF_EARLY_CYC < 1 ||
      OFF_LATE_CYC < 1 || RESTART_ON_CYC < 1) begin : g_bad_time
    $error("lock_rotor_protect_drive timing counts must be at least 1");
  end

  logic [2:0]  pins_sync;
  logic        hall_pos_s;
  logic        hall_neg_s;
  logic        oc_s;

  pin_sync #(.WIDTH(3)) u_pin_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .pin_in   ({current_sense_in, hall_in_neg, hall_in_pos}),
    .sync_out (pins_sync)
  );

  assign hall_pos_s = pins_sync[0];
  assign hall_neg_s = pins_sync[1];
  assign oc_s       = pins_sync[2];

  // Hall phase: a comparator pair that disagrees decides; agreement holds the last phase
  logic hall_phase;
  logic next_hall_phase;
  logic phase_known;
  logic next_phase_known;
  logic comm_edge;

  always_comb begin
    next_hall_phase  = hall_phase;
    next_phase_known = phase_known;
    if (clk_en && (hall_pos_s != hall_neg_s)) begin
      next_hall_phase  = hall_pos_s;
      next_phase_known = 1'b1;
    end
  end

  // The first valid phase after reset is a load, not a commutation
  assign comm_edge = clk_en && phase_known && (next_hall_phase != hall_phase);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hall_phase  <= 1'b0;
      phase_known <= 1'b0;
    end else begin
      hall_phase  <= next_hall_phase;
      phase_known <= next_phase_known;
    end
  end

  // Protection sequencer
  lock_state_t state;
  lock_state_t next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [2:0]  next_off_count;
  logic        late_off;

  assign late_off = off_period_count > EARLY_PERIODS;

  always_comb begin
    next_state     = state;
    next_timer     = timer;
    next_off_count = off_period_count;
    if (clk_en) begin
      next_timer = timer + 32'h1;
      case (state)
        ST_IDLE: begin
          next_timer = '0;
          if (run_cmd) begin
            next_state = ST_STARTUP;
          end
        end
        ST_STARTUP: begin
          if (comm_edge) begin
            next_state = ST_RUN;
            next_timer = '0;
          end else if (timer == START_LOCK_CYC - 1) begin
            next_state     = ST_LOCKOFF;
            next_timer     = '0;
            next_off_count = 3'h1;
          end
        end
        ST_RUN: begin
          if (comm_edge) begin
            next_timer = '0;
          end else if (timer == RUN_LOCK_CYC - 1) begin
            next_state     = ST_LOCKOFF;
            next_timer     = '0;
            next_off_count = 3'h1;
          end
        end
        ST_LOCKOFF: begin
          // Hall edges while coasting are ignored; only a restart proves recovery
          if ((!late_off && timer == OFF_EARLY_CYC - 1) ||
              (late_off && timer == OFF_LATE_CYC - 1)) begin
            next_state = ST_RESTART;
            next_timer = '0;
          end
        end
        ST_RESTART: begin
          if (comm_edge) begin
            next_state     = ST_RUN;
            next_timer     = '0;
            next_off_count = '0;
          end else if (timer == RESTART_ON_CYC - 1) begin
            next_state = ST_LOCKOFF;
            next_timer = '0;
            // Saturates at the seventh period so the long off time sticks
            if (off_period_count != 3'h7) begin
              next_off_count = off_period_count + 3'h1;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_timer = '0;
        end
      endcase
      if (!run_cmd) begin
        next_state     = ST_IDLE;
        next_timer     = '0;
        next_off_count = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state            <= ST_IDLE;
      timer            <= '0;
      off_period_count <= '0;
    end else begin
      state            <= next_state;
      timer            <= next_timer;
      off_period_count <= next_off_count;
    end
  end

  // Output stage
  gate_drive_t next_gate;
  logic        drive_on;
  logic        next_limiter;
  logic        next_locked;
  logic        next_fg;

  assign drive_on = (next_state == ST_STARTUP) || (next_state == ST_RUN) ||
                    (next_state == ST_RESTART);

  always_comb begin
    next_gate    = gate_drive;
    next_limiter = overcurrent_limiter;
    next_locked  = rotor_locked;
    next_fg      = speed_pulse_out_oe;
    if (clk_en) begin
      next_limiter = oc_s;
      next_locked  = (next_state == ST_LOCKOFF) || (next_state == ST_RESTART);
      next_fg      = ~next_hall_phase;
      next_gate    = '0;
      if (drive_on) begin
        if (oc_s) begin
          // Regenerate through both low sides; never leaves a leg shorted
          next_gate.gate_low_a = 1'b1;
          next_gate.gate_low_b = 1'b1;
        end else if (next_hall_phase) begin
          next_gate.gate_high_a = 1'b1;
          next_gate.gate_low_b  = 1'b1;
        end else begin
          next_gate.gate_high_b = 1'b1;
          next_gate.gate_low_a  = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate_drive          <= '0;
      overcurrent_limiter <= 1'b0;
      rotor_locked        <= 1'b0;
      speed_pulse_out_oe  <= 1'b0;
      speed_pulse_out_o   <= 1'b0;
    end else begin
      gate_drive          <= next_gate;
      overcurrent_limiter <= next_limiter;
      rotor_locked        <= next_locked;
      speed_pulse_out_oe  <= next_fg;
      speed_pulse_out_o   <= 1'b0;
    end
  end

  // Checks
  chk_run_lock_time: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_LOCKOFF && $past(state) == ST_RUN) |-> $past(timer) == RUN_LOCK_CYC - 1)
    else $error("running lock declared at wrong time");

  chk_start_lock_time: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_LOCKOFF && $past(state) == ST_STARTUP)
      |-> $past(timer) == START_LOCK_CYC - 1)
    else $error("start-up lock declared at wrong time");

  chk_early_off_len: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_RESTART && $past(state) == ST_LOCKOFF && off_period_count <= EARLY_PERIODS)
      |-> $past(timer) == OFF_EARLY_CYC - 1)
    else $error("early off period has wrong length");

  chk_late_off_len: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_RESTART && $past(state) == ST_LOCKOFF && off_period_count > EARLY_PERIODS)
      |-> $past(timer) == OFF_LATE_CYC - 1)
    else $error("late off period has wrong length");

  chk_restart_on_len: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_LOCKOFF && $past(state) == ST_RESTART)
      |-> $past(timer) == RESTART_ON_CYC - 1 && gate_drive == '0)
    else $error("restart on-time has wrong length");

  chk_limiter_follow: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && oc_s) |=> overcurrent_limiter)
    else $error("limiter did not follow sense comparator");

  chk_limiter_regen: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && oc_s && drive_on)
      |=> gate_drive == gate_drive_t'{1'b0, 1'b1, 1'b0, 1'b1})
    else $error("bridge not regenerating under current limit");

  chk_gate_no_short: assert property (@(posedge clk) disable iff (sys_rst)
    !(gate_drive.gate_high_a && gate_drive.gate_low_a) &&
    !(gate_drive.gate_high_b && gate_drive.gate_low_b))
    else $error("both FETs of one leg driven");

  chk_speed_toggle: assert property (@(posedge clk) disable iff (sys_rst)
    comm_edge |=> speed_pulse_out_oe != $past(speed_pulse_out_oe) && !speed_pulse_out_o)
    else $error("speed pulse did not toggle on commutation");

  chk_recover_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_RUN && $past(state) == ST_RESTART) |-> off_period_count == 3'h0 && !rotor_locked)
    else $error("recovery did not clear off count");

endmodule

`default_nettype wire

/* common/lrp_defs.svh */
// Timing constants for the locked-rotor protection block
`ifndef LRP_DEFS_SVH
`define LRP_DEFS_SVH

`define LRP_CLK_KHZ           125000
`define LRP_RUN_LOCK_MS       300
`define LRP_START_LOCK_MS     700
`define LRP_OFF_EARLY_MS      3500
`define LRP_OFF_LATE_MS       14000
`define LRP_RESTART_ON_MS     700
`define LRP_EARLY_OFF_PERIODS 4
`define LRP_OC_THRESHOLD_MV   100

`define LRP_RUN_LOCK_CYC   (`LRP_RUN_LOCK_MS * `LRP_CLK_KHZ)
`define LRP_START_LOCK_CYC (`LRP_START_LOCK_MS * `LRP_CLK_KHZ)
`define LRP_OFF_EARLY_CYC  (`LRP_OFF_EARLY_MS * `LRP_CLK_KHZ)
`define LRP_OFF_LATE_CYC   (`LRP_OFF_LATE_MS * `LRP_CLK_KHZ)
`define LRP_RESTART_ON_CYC (`LRP_RESTART_ON_MS * `LRP_CLK_KHZ)

`endif

/* common/lrp_pkg.sv */
// Types shared by the locked-rotor protection block
package lrp_pkg;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_STARTUP = 5'h02,
    ST_RUN     = 5'h04,
    ST_LOCKOFF = 5'h08,
    ST_RESTART = 5'h10
  } lock_state_t;

  typedef struct packed {
    logic gate_high_a;
    logic gate_low_a;
    logic gate_high_b;
    logic gate_low_b;
  } gate_drive_t;

endpackage

/* rtl/pin_sync.sv */
// Two-stage synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs WIDTH of at least 1");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      next_meta[i] = clk_en ? pin_in[i] : meta[i];
      next_sync[i] = clk_en ? meta[i] : sync_out[i];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end

endmodule

`default_nettype wire

/* verification/fan_motor_model.sv */
// Behavioural fan motor with Hall sensor and pulled-up speed pin
`timescale 1ns/1ns
`default_nettype none
module fan_motor_model #(
  parameter int HALF = 8
) (
  input  wire logic                 clk,
  input  wire lrp_pkg::gate_drive_t gate_drive,
  input  wire logic                 stuck,
  input  wire logic                 pin_oe,
  output logic                      hall_pos,
  output logic                      hall_neg,
  output logic                      speed_pin
);
  import lrp_pkg::*;
  int   cnt   = 0;
  logic phase = 1'b0;
  // Rotor only advances while some transistor conducts and it is free
  always @(posedge clk) begin
    if (gate_drive != '0 && !stuck) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        phase <= ~phase;
      end
    end
  end
  assign hall_pos = phase;
  assign hall_neg = ~phase;
  // Pull-up holds the open-drain line high when released
  assign speed_pin = pin_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the locked-rotor protection block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lrp_pkg::*;
  localparam int RUN = 30, START = 70, OFF_E = 35, OFF_L = 140, ON_T = 70;
  logic        clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, run_cmd = 1'b0;
  logic        current_sense_in = 1'b0, stuck = 1'b1;
  logic        hall_in_pos, hall_in_neg, speed_pin, speed_pulse_out_o;
  logic        speed_pulse_out_oe, overcurrent_limiter, rotor_locked;
  logic [2:0]  off_period_count;
  gate_drive_t gate_drive;
  int          err_count = 0, num_checks = 0, cycles = 0, n;
  always #4 clk = ~clk;
  lock_rotor_protect_drive #(.RUN_LOCK_CYC(RUN), .START_LOCK_CYC(START),
    .OFF_EARLY_CYC(OFF_E), .OFF_LATE_CYC(OFF_L), .RESTART_ON_CYC(ON_T)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .run_cmd(run_cmd),
    .hall_in_pos(hall_in_pos), .hall_in_neg(hall_in_neg),
    .current_sense_in(current_sense_in), .gate_drive(gate_drive),
    .speed_pulse_out_o(speed_pulse_out_o), .speed_pulse_out_oe(speed_pulse_out_oe),
    .overcurrent_limiter(overcurrent_limiter), .rotor_locked(rotor_locked),
    .off_period_count(off_period_count));
  fan_motor_model #(.HALF(8)) motor_u (.clk(clk), .gate_drive(gate_drive),
    .stuck(stuck), .pin_oe(speed_pulse_out_oe), .hall_pos(hall_in_pos),
    .hall_neg(hall_in_neg), .speed_pin(speed_pin));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Length of the current run of gates off (or on), bounded
  task automatic span(input logic off);
    n = 0;
    while (((gate_drive == '0) == off) && n < 400) begin
      n++;
      @(negedge clk);
    end
  endtask
  task automatic hall_turn;
    logic h;
    h = hall_in_pos;
    n = 0;
    while (hall_in_pos === h && n < 40) begin
      n++;
      @(negedge clk);
    end
  endtask
  task automatic t_reset;
    chk("locked", 8'h00, 8'(rotor_locked));
    chk("gates", 8'h00, 8'(gate_drive));
  endtask
  task automatic t_startup_lock;
    run_cmd = 1'b1;
    n = 0;
    while (rotor_locked !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("startup lock", 8'(START + 1), 8'(n));
    chk("gates off", 8'h00, 8'(gate_drive));
  endtask
  task automatic t_restart_cycle;
    for (int k = 1; k <= 5; k++) begin
      chk("off count", 8'(k), 8'(off_period_count));
      span(1'b1);
      chk("off time", 8'(k > 4 ? OFF_L : OFF_E), 8'(n));
      chk("locked", 8'h01, 8'(rotor_locked));
      if (k < 5) begin
        span(1'b0);
        chk("on time", 8'(ON_T), 8'(n));
      end
    end
  endtask
  task automatic t_recover;
    cyc(5);
    stuck = 1'b0;
    n = 0;
    while (rotor_locked !== 1'b0 && n < 40) begin
      n++;
      @(negedge clk);
    end
    chk("unlocked", 8'h00, 8'(rotor_locked));
    chk("count cleared", 8'h00, 8'(off_period_count));
  endtask
  task automatic t_run_outputs;
    repeat (2) begin
      hall_turn();
      cyc(4);
      chk("speed oe", 8'(!hall_in_pos), 8'(speed_pulse_out_oe));
      chk("speed pin", 8'(hall_in_pos), 8'(speed_pin));
      chk("speed out", 8'h00, 8'(speed_pulse_out_o));
      chk("gates", hall_in_pos ? 8'h09 : 8'h06, 8'(gate_drive));
    end
  endtask
  task automatic t_overcurrent;
    current_sense_in = 1'b1;
    cyc(4);
    chk("limiter on", 8'h01, 8'(overcurrent_limiter));
    chk("regen gates", 8'h05, 8'(gate_drive));
    current_sense_in = 1'b0;
    cyc(4);
    chk("limiter off", 8'h00, 8'(overcurrent_limiter));
  endtask
  task automatic t_run_lock;
    hall_turn();
    stuck = 1'b1;
    cyc(5);
    // A frozen clock enable must stall the lock timer and hold the gates
    clk_en = 1'b0;
    cyc(10);
    chk("frozen gates", hall_in_pos ? 8'h09 : 8'h06, 8'(gate_drive));
    chk("frozen locked", 8'h00, 8'(rotor_locked));
    clk_en = 1'b1;
    n = 15;
    while (rotor_locked !== 1'b1 && n < 60) begin
      n++;
      @(negedge clk);
    end
    chk("run lock time", 8'(RUN + 13), 8'(n));
    chk("run lock gates", 8'h00, 8'(gate_drive));
  endtask
  task automatic t_stop;
    run_cmd = 1'b0;
    cyc(2);
    chk("idle locked", 8'h00, 8'(rotor_locked));
    chk("idle count", 8'h00, 8'(off_period_count));
    chk("idle gates", 8'h00, 8'(gate_drive));
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Whole run needs well under 1500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_startup_lock();
    t_restart_cycle();
    t_recover();
    t_run_outputs();
    t_overcurrent();
    t_run_lock();
    t_stop();
    complete_run();
  end
endmodule
`default_nettype wire
